// *** bench/mailbox_core_properties.sv ***
// Checker on the reader command port of the mailbox core
`timescale 1ns/1ps
`include "mailbox_cfg.svh"
module mailbox_core_properties
  import mailbox_pkg::*;
(
  input wire logic               mclk_in,           // Clock
  input wire logic               rst_n_in,          // Reset, low
  input wire logic               ext_mode_in,       // Extended mode
  input wire logic               rf_req_in,         // Reader request
  input wire logic               rf_write_in,       // Write or read
  input wire logic [7:0]         rf_block_in,       // Block address
  input wire logic               rf_frame_err_in,   // Bad frame
  input wire mailbox_pkg::resp_e rf_resp_out,       // Answer kind
  input wire logic               rf_resp_valid_out, // Answer strobe
  input wire logic [127:0]       rf_rdata_out,      // Read answer
  input wire logic               mem_write_out      // Memory write
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic good;
  // A request that arrived without a frame fault
  assign good = rf_req_in && !rf_frame_err_in;
  //////////////////////////////////////////////////////////////////////////
  a_answer_follows: assert property (good |=> rf_resp_valid_out)
    else $error("No answer after a good request");
  a_bad_frame_silent: assert property (rf_req_in && rf_frame_err_in |=> !rf_resp_valid_out)
    else $error("Answer given to a bad frame");
  a_answer_has_cause: assert property (rf_resp_valid_out |-> $past(good))
    else $error("Answer without a request");
  a_answer_kind: assert property (rf_resp_valid_out
    |-> rf_resp_out inside {RESP_ACK, RESP_ERR})
    else $error("Answer kind is none");
  a_other_read_err: assert property (good && !rf_write_in && ext_mode_in
    && rf_block_in > `BLK_FIRST |=> rf_resp_out == RESP_ERR)
    else $error("Read of a later mailbox block accepted");
  a_low_write_mem: assert property (good && rf_write_in && rf_block_in < `BLK_FIRST
    |-> mem_write_out)
    else $error("Memory write not passed on");
  a_box_write_local: assert property (good && rf_write_in && ext_mode_in
    && rf_block_in >= `BLK_FIRST |-> !mem_write_out)
    else $error("Mailbox write reached memory");
  a_rdata_held: assert property (!(good && !rf_write_in && rf_block_in == `BLK_FIRST)
    |=> $stable(rf_rdata_out))
    else $error("Read answer changed without a read");
  c_ack: cover property (rf_resp_valid_out && rf_resp_out == RESP_ACK);
  c_err: cover property (rf_resp_valid_out && rf_resp_out == RESP_ERR);
  c_mem: cover property (mem_write_out);
  c_ready: cover property (rf_resp_valid_out && rf_rdata_out[127:120] == 8'h01);
endmodule
bind mailbox_core mailbox_core_properties i_props (.mclk_in, .rst_n_in, .ext_mode_in,
  .rf_req_in, .rf_write_in, .rf_block_in, .rf_frame_err_in, .rf_resp_out,
  .rf_resp_valid_out, .rf_rdata_out, .mem_write_out);

// *** bench/mailbox_core_tb.sv ***
// Testbench for the mailbox core
`timescale 1ns/1ps
`include "mailbox_cfg.svh"
module mailbox_core_tb;
  import mailbox_pkg::*;
  logic         mclk_in = 1'b0, rst_n_in = 1'b0, field_reset_in = 1'b0, ext_mode_in = 1'b1;
  logic         rf_req_in, rf_write_in, rf_frame_err_in, rf_resp_valid_out, mem_write_out;
  logic         reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0]   rf_block_in, reg_wdata_in = 8'h00, reg_rdata_out;
  logic [2:0]   reg_addr_in = 3'h0;
  logic [31:0]  rf_wdata_in;
  logic [127:0] rf_rdata_out, exp;
  resp_e        rf_resp_out;
  int           n_errors = 0, check_count = 0;
  always #20 mclk_in = ~mclk_in;
  mailbox_core i_mailbox_core (.mclk_in, .rst_n_in, .field_reset_in, .ext_mode_in,
    .rf_req_in, .rf_write_in, .rf_block_in, .rf_wdata_in, .rf_frame_err_in, .rf_resp_out,
    .rf_resp_valid_out, .rf_rdata_out, .mem_write_out, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out);
  mailbox_reader i_mailbox_reader (.mclk_in, .resp_in(rf_resp_out),
    .valid_in(rf_resp_valid_out), .rdata_in(rf_rdata_out), .mem_in(mem_write_out),
    .req_out(rf_req_in), .write_out(rf_write_in), .block_out(rf_block_in),
    .wdata_out(rf_wdata_in), .ferr_out(rf_frame_err_in));
  //////////////////////////////////////////////////////////////////////////
  // Compare, count and report
  task automatic chk(input logic [127:0] got, input logic [127:0] want);
    check_count++;
    if (got !== want) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // Register write and read, one strobe cycle each
  task automatic rw(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] want);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, want);
  endtask
  // Reader command with its expected answer kind
  task automatic rfc(input logic w, input logic [7:0] b, input logic [31:0] d,
                     input resp_e want);
    i_mailbox_reader.cmd(w, b, d, 1'b0);
    chk(i_mailbox_reader.got_resp, want);
    chk(i_mailbox_reader.got_valid, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Reader message in, host reads it, buffer freed
  task automatic t_rx;
    rw(`REG_EVENTS, 8'h0f);
    // four blocks from first to last
    for (int b = 0; b < 4; b++) begin
      rfc(1'b1, 8'(8'hfc + b), 32'(32'h03020100 + 32'h04040404 * b), RESP_ACK);
      if (b == 0) begin
        rc(`REG_EVENTS, 8'h01);
        rc(`REG_STATUS, 8'h06);
        rc(`REG_BUF_DATA, 8'h00);
        rw(`REG_BUF_DATA, 8'haa);
        rc(`REG_EVENTS, 8'h09);
      end
    end
    rc(`REG_EVENTS, 8'h0b);
    rc(`REG_STATUS, 8'h0a);
    rfc(1'b1, 8'hfc, 32'hffffffff, RESP_ERR);
    for (int n = 0; n < 16; n++) rc(`REG_BUF_DATA, 8'(n));
    rw(`REG_CMD, `CMD_CLEAR);
    rc(`REG_STATUS, 8'h02);
    rfc(1'b1, 8'hfc, 32'h0, RESP_ACK);
    @(posedge mclk_in);
    field_reset_in <= 1'b1;
    @(posedge mclk_in);
    field_reset_in <= 1'b0;
    rc(`REG_STATUS, 8'h02);
    rfc(1'b1, 8'hff, 32'h0, RESP_ERR);
    i_mailbox_reader.cmd(1'b1, 8'hfc, 32'h0, 1'b1);
    chk(i_mailbox_reader.got_valid, 1'b0);
  endtask
  // Host message out to the reader
  task automatic t_tx;
    i_mailbox_reader.cmd(1'b0, 8'hfc, 32'h0, 1'b0);
    chk(i_mailbox_reader.got_data, {8'h02, 120'h0});
    rfc(1'b0, 8'hfd, 32'h0, RESP_ERR);
    // host empties the buffer before loading
    rw(`REG_CMD, `CMD_CLEAR);
    exp = '0;
    for (int n = 0; n < 12; n++) begin
      rw(`REG_BUF_DATA, 8'(8'h40 + n));
      exp[8*n+:8] = 8'(8'h40 + n);
    end
    exp[127:120] = `FLAGS_READY;
    rc(`REG_BUF_POS, 8'h0c);
    rw(`REG_CMD, `CMD_TRANSMIT);
    rc(`REG_STATUS, 8'h01);
    rw(`REG_EVENTS, 8'h0f);
    // poll until the flags byte reads one
    for (int p = 0; p < 8; p++) begin
      i_mailbox_reader.cmd(1'b0, 8'hfc, 32'h0, 1'b0);
      if (i_mailbox_reader.got_data[127:120] === `FLAGS_READY) break;
    end
    chk(i_mailbox_reader.got_data, exp);
    rfc(1'b1, 8'hff, 32'h0, RESP_ACK);
    rc(`REG_EVENTS, 8'h04);
  endtask
  // Memory write cutting into a reader message; broken on purpose
  task automatic t_mem;
    rfc(1'b1, 8'hfc, 32'h0, RESP_ACK);
    i_mailbox_reader.cmd(1'b1, 8'h10, 32'h12345678, 1'b0);
    chk(i_mailbox_reader.got_mem, 1'b1);
    rc(`REG_STATUS, 8'h02);
    // With extended mode off the mailbox blocks fall through to memory
    @(posedge mclk_in);
    ext_mode_in <= 1'b0;
    rc(`REG_CTRL, 8'h00);
    i_mailbox_reader.cmd(1'b1, 8'hfc, 32'h0, 1'b0);
    chk(i_mailbox_reader.got_mem, 1'b1);
    chk(i_mailbox_reader.got_resp, RESP_ACK);
    rc(`REG_STATUS, 8'h02);
    @(posedge mclk_in);
    ext_mode_in <= 1'b1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence after a four-cycle reset
  initial begin
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_rx;
    t_tx;
    t_mem;
    conclude;
  end
  // Watchdog against a hang
  initial begin
    #100000;
    n_errors++;
    conclude;
  end
endmodule

// *** bench/mailbox_reader.sv ***
// Reader model that issues one block command at a time
`timescale 1ns/1ps
module mailbox_reader
  import mailbox_pkg::*;
(
  input  wire logic               mclk_in,          // Clock
  input  wire mailbox_pkg::resp_e resp_in,          // Answer kind
  input  wire logic               valid_in,         // Answer strobe
  input  wire logic [127:0]       rdata_in,         // Read answer
  input  wire logic               mem_in,           // Memory write
  output logic                    req_out = 1'b0,   // Request
  output logic                    write_out = 1'b0, // Write or read
  output logic [7:0]              block_out = 8'h00, // Block
  output logic [31:0]             wdata_out = '0,   // Write data
  output logic                    ferr_out = 1'b0   // Bad frame
);
  logic         got_valid, got_mem;
  logic [2:0]   got_resp;
  logic [127:0] got_data;
  // One request cycle, answer taken just after the next edge
  // a bad frame is flagged alongside its request
  task automatic cmd(input logic w, input logic [7:0] b, input logic [31:0] d,
                     input logic fe);
    @(posedge mclk_in);
    req_out <= 1'b1;
    write_out <= w;
    block_out <= b;
    wdata_out <= d;
    ferr_out <= fe;
    @(negedge mclk_in);
    got_mem = mem_in;
    @(posedge mclk_in);
    req_out <= 1'b0;
    ferr_out <= 1'b0;
    // Released lines show no stale copy
    block_out <= ~b;
    wdata_out <= ~d;
    #1;
    got_valid = valid_in;
    got_resp = resp_in;
    got_data = rdata_in;
  endtask
endmodule

// *** verilog/mailbox_buffer.sv ***
// Sixteen-byte mailbox store with one shared 4-byte block write port, a host byte write port and a flat read of all bytes
`timescale 1ns/1ps
`include "mailbox_cfg.svh"
module mailbox_buffer #(
  parameter int BYTES = `BUF_BYTES
) (
  input  wire logic                  mclk_in,   // Clock
  input  wire logic                  rst_n_in,  // Async reset, low
  input  wire logic                  clr_in,    // Clear all bytes
  input  wire logic                  blk_we_in, // Write one 4-byte block
  input  wire logic [1:0]            blk_in,    // Block index
  input  wire logic [31:0]           blk_data_in, // Block data, byte 0 low
  input  wire logic                  byte_we_in,  // Host byte write
  input  wire logic [`POS_W-1:0]     pos_in,      // Host byte position
  input  wire logic [7:0]            byte_in,     // Host byte data
  output logic      [8*BYTES-1:0]    mem_out      // All bytes, flat
);
  logic [7:0] mem [BYTES];

  // One storage byte per entry
  genvar i;
  generate
    for (i = 0; i < BYTES; i++) begin : g_byte
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          mem[i] <= 8'h00;
        end else if (clr_in) begin
          mem[i] <= 8'h00;
        end else if (blk_we_in && (blk_in == 2'(i / 4))) begin
          mem[i] <= blk_data_in[8*(i%4) +: 8];
        end else if (byte_we_in && (pos_in == `POS_W'(i))) begin
          mem[i] <= byte_in;
        end
      end
      assign mem_out[8*i +: 8] = mem[i];
    end
  endgenerate
endmodule

// *** verilog/mailbox_cfg.svh ***
// Constants for the extended-mode reader/host mailbox
`ifndef MAILBOX_CFG_SVH
`define MAILBOX_CFG_SVH
`define BLK_FIRST      8'hfc
`define BLK_THIRD      8'hfe
`define BLK_LAST       8'hff
`define BUF_BYTES      16
`define HOST_BYTES     12
`define POS_W          4
`define POS_ZERO       4'h0
`define POS_LAST       4'hf
`define RADDR_W        3
`define REG_STATUS     3'h0
`define REG_CTRL       3'h1
`define REG_EVENTS     3'h2
`define REG_BUF_DATA   3'h3
`define REG_CMD        3'h4
`define REG_BUF_POS    3'h5
`define CMD_CLEAR      8'h01
`define CMD_TRANSMIT   8'h02
`define ST_HOST_RDY    0
`define ST_HOST_BUSY   1
`define ST_RD_WIP      2
`define ST_RD_PEND     3
`define EV_RXS         0
`define EV_RXE         1
`define EV_TXE         2
`define EV_ACC         3
`define EV_W           4
`define EV_ZERO        4'h0
`define FLAGS_READY    8'h01
`endif

// *** verilog/mailbox_core.sv ***
// Extended-mode mailbox between an RF reader and a host controller
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "mailbox_cfg.svh"
module mailbox_core
  import mailbox_pkg::*;
#(
  parameter int BYTES = `BUF_BYTES
) (
  input  wire logic               mclk_in,        // 25 MHz clock
  input  wire logic               rst_n_in,       // Async reset, low
  input  wire logic               field_reset_in, // RF field cycled, pulse
  input  wire logic               ext_mode_in,    // Extended mode enabled
  // Reader command side, one-cycle request
  input  wire logic               rf_req_in,      // Reader command valid
  input  wire logic               rf_write_in,    // 1 write, 0 read
  input  wire logic [7:0]         rf_block_in,    // Block address
  input  wire logic [31:0]        rf_wdata_in,    // Write data, byte 0 low
  input  wire logic               rf_frame_err_in,// CRC or framing error
  output mailbox_pkg::resp_e      rf_resp_out,    // Answer kind
  output logic                    rf_resp_valid_out, // Answer strobe
  output logic [8*BYTES-1:0]      rf_rdata_out,   // Read answer bytes
  output logic                    mem_write_out,  // Pass write to memory
  // Register port
  input  wire logic [`RADDR_W-1:0] reg_addr_in,   // Register index
  input  wire logic [7:0]         reg_wdata_in,   // Write data
  input  wire logic               reg_wr_in,      // Write strobe
  input  wire logic               reg_rd_in,      // Read strobe
  output logic [7:0]              reg_rdata_out   // Read data, next cycle
);
  // Mailbox owner, host pointer, sticky events and decoded strobes
  mb_state_e       state;
  logic [`POS_W-1:0] pos;
  logic [`EV_W-1:0] events;
  logic            host_rdy;
  logic            host_busy;
  logic            buf_clr;
  logic            blk_we;
  logic            byte_we;
  logic [8*BYTES-1:0] mem;
  logic [8*BYTES-1:0] resp;
  logic            is_mb;
  logic            wr_first;
  logic            wr_last;
  logic            wr_mid;
  logic            rd_ok;
  logic            host_wr;
  logic            host_rd;
  logic            host_lock;
  logic            cmd_clear;
  logic            cmd_tx;
  logic [`EV_W-1:0] ev_set;
  logic [`EV_W-1:0] ev_clr;
  logic            mem_wr;
  resp_e           next_resp;

  //////////////////////////////////////////////////////////////////////////
  // Request decode

  // In extended mode the top blocks never reach memory; the two low
  // address bits then pick the 4-byte slot in the buffer
  // blocks to buffer
  assign is_mb    = ext_mode_in && (rf_block_in >= `BLK_FIRST);
  assign wr_first = rf_req_in && rf_write_in && is_mb && !rf_frame_err_in
                    && (rf_block_in == `BLK_FIRST);
  assign wr_last  = rf_req_in && rf_write_in && is_mb && !rf_frame_err_in
                    && (rf_block_in == `BLK_LAST);
  assign wr_mid   = rf_req_in && rf_write_in && is_mb && !rf_frame_err_in
                    && !wr_first && !wr_last;
  // A faulty read frame must not refresh the held answer either
  // only first block readable
  assign rd_ok    = rf_req_in && !rf_write_in && is_mb && !rf_frame_err_in
                    && (rf_block_in == `BLK_FIRST);
  // Below the mailbox a write goes to memory; a message in flight is lost
  // memory writes pass on
  assign mem_wr   = rf_req_in && rf_write_in && !is_mb && !rf_frame_err_in;
  assign mem_write_out = mem_wr;

  assign host_rdy  = (state == MB_TX);
  // Host side counts as occupied until Transmit Buffer hands data over
  // busy unless data is ready
  assign host_busy = !host_rdy;
  // Only a message in flight locks the host out; a pending one may be read
  // host locked out
  assign host_lock = (state == MB_RX);
  assign host_wr   = reg_wr_in && (reg_addr_in == `REG_BUF_DATA);
  assign host_rd   = reg_rd_in && (reg_addr_in == `REG_BUF_DATA);
  // Commands are ignored while locked, so a clear cannot cut a reader message
  assign cmd_clear = reg_wr_in && (reg_addr_in == `REG_CMD)
                     && (reg_wdata_in == `CMD_CLEAR) && !host_lock;
  assign cmd_tx    = reg_wr_in && (reg_addr_in == `REG_CMD)
                     && (reg_wdata_in == `CMD_TRANSMIT) && !host_lock;
  assign byte_we   = host_wr && !host_lock && (state != MB_RX_DONE);

  //////////////////////////////////////////////////////////////////////////
  // Reader answer selection
  // Picks ACK or error for each good request and the buffer writes it makes;
  // a field cycle or host clear empties the buffer in the same cycle
  always_comb begin
    next_resp = RESP_NONE;
    blk_we    = 1'b0;
    buf_clr   = 1'b0;
    if (rf_req_in) begin
      if (rf_frame_err_in) begin
        next_resp = RESP_NONE;
      end else if (!rf_write_in) begin
        next_resp = (rd_ok || !is_mb) ? RESP_ACK : RESP_ERR;
      end else if (mem_wr) begin
        next_resp = RESP_ACK;
        buf_clr   = (state == MB_RX);
      end else begin
        case (state)
          MB_EMPTY: begin
            next_resp = wr_first ? RESP_ACK : RESP_ERR;
            blk_we    = wr_first;
          end
          MB_RX: begin
            // A repeated first block would restart the message, so it is refused
            next_resp = (wr_mid || wr_last) ? RESP_ACK : RESP_ERR;
            blk_we    = wr_mid || wr_last;
          end
          MB_RX_DONE: begin
            next_resp = RESP_ERR;
          end
          MB_TX: begin
            next_resp = wr_last ? RESP_ACK : RESP_ERR;
            buf_clr   = wr_last;
          end
          default: begin
            next_resp = RESP_ERR;
          end
        endcase
      end
    end
    if (field_reset_in || cmd_clear) begin
      buf_clr = 1'b1;
    end
  end

  // Answer strobe and data registers
  // The answer lands one cycle after the request; read data are held until
  // the next good read of the first block, so the reader may fetch them late
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rf_resp_out       <= RESP_NONE;
      rf_resp_valid_out <= 1'b0;
      rf_rdata_out      <= '0;
    end else begin
      rf_resp_out       <= next_resp;
      rf_resp_valid_out <= rf_req_in && !rf_frame_err_in;
      if (rd_ok) begin
        rf_rdata_out <= resp;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mailbox state
  // One-hot owner: empty, reader writing, reader data pending, host data out
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= MB_EMPTY;
    end else if (field_reset_in) begin
      state <= MB_EMPTY;
    end else begin
      case (state)
        MB_EMPTY: begin
          // Either side may claim an empty buffer; the reader wins a tie
          if (wr_first) begin
            state <= MB_RX;
          end else if (cmd_tx) begin
            state <= MB_TX;
          end
        end
        MB_RX: begin
          if (mem_wr) begin
            state <= MB_EMPTY;
          end else if (wr_last) begin
            state <= MB_RX_DONE;
          end
        end
        MB_RX_DONE: begin
          // Reader data wait here until the host clears them
          // clear drops pending
          if (cmd_clear) begin
            state <= MB_EMPTY;
          end
        end
        MB_TX: begin
          // Reader release or a host clear ends the outgoing transfer
          if (wr_last || cmd_clear) begin
            state <= MB_EMPTY;
          end
        end
        default: begin
          state <= MB_EMPTY;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Host byte pointer
  // Advances once per accepted buffer access so bytes stream in order;
  // a refused access leaves it where it is
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos <= `POS_ZERO;
    end else if (buf_clr || field_reset_in) begin
      pos <= `POS_ZERO;
    end else if (byte_we || (host_rd && !host_lock)) begin
      pos <= pos + `POS_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sticky events, cleared by writing ones; a new event wins
  // Each event comes from a decoded strobe of this cycle
  always_comb begin
    ev_set = `EV_ZERO;
    ev_set[`EV_RXS] = wr_first && (state == MB_EMPTY);
    ev_set[`EV_RXE] = wr_last && (state == MB_RX);
    ev_set[`EV_TXE] = wr_last && (state == MB_TX);
    // Any buffer or command access while locked counts as a conflict
    // access conflict
    ev_set[`EV_ACC] = (host_wr || host_rd || (reg_wr_in && (reg_addr_in == `REG_CMD)))
                      && host_lock;
    ev_clr = (reg_wr_in && (reg_addr_in == `REG_EVENTS)) ? reg_wdata_in[`EV_W-1:0]
                                                          : `EV_ZERO;
  end

  // Write-one-to-clear; an event in the clearing cycle stays set
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      events <= `EV_ZERO;
    end else begin
      events <= (events & ~ev_clr) | ev_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register reads, data one cycle after the strobe
  // Outside that cycle the data return to zero, so no stale value shows
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `REG_STATUS: begin
          // Bits: pending, in progress, host busy, host ready
          reg_rdata_out <= {4'h0, state == MB_RX_DONE, state == MB_RX,
                            host_busy && !host_rdy, host_rdy};
        end
        `REG_CTRL: begin
          reg_rdata_out <= {7'h00, ext_mode_in};
        end
        `REG_EVENTS: begin
          reg_rdata_out <= {4'h0, events};
        end
        `REG_BUF_DATA: begin
          // A locked buffer reads as zero rather than half-written data
          reg_rdata_out <= host_lock ? 8'h00 : mem[8*pos +: 8];
        end
        `REG_BUF_POS: begin
          reg_rdata_out <= {4'h0, pos};
        end
        default: begin
          reg_rdata_out <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Buffer and reader answer builder
  // The buffer clears in one cycle; block writes win over a host byte write
  mailbox_buffer #(.BYTES(BYTES)) u_buf (
    .mclk_in    (mclk_in),
    .rst_n_in   (rst_n_in),
    .clr_in     (buf_clr),
    .blk_we_in  (blk_we),
    .blk_in     (rf_block_in[1:0]),
    .blk_data_in(rf_wdata_in),
    .byte_we_in (byte_we),
    .pos_in     (pos),
    .byte_in    (reg_wdata_in),
    .mem_out    (mem)
  );

  // Host data show to the reader only once Transmit Buffer was given
  // flags byte
  mailbox_resp #(.BYTES(BYTES)) u_resp (
    .mem_in      (mem),
    .host_rdy_in (host_rdy),
    .host_busy_in(host_busy),
    .resp_out    (resp)
  );
endmodule

// *** verilog/mailbox_pkg.sv ***
// Types shared by the mailbox design files
package mailbox_pkg;
  typedef enum logic [2:0] {
    RESP_NONE = 3'b001,
    RESP_ACK  = 3'b010,
    RESP_ERR  = 3'b100
  } resp_e;
  typedef enum logic [3:0] {
    MB_EMPTY   = 4'b0001,
    MB_RX      = 4'b0010,
    MB_RX_DONE = 4'b0100,
    MB_TX      = 4'b1000
  } mb_state_e;
  typedef logic [7:0] byte_t;
endpackage

// *** verilog/mailbox_resp.sv ***
// Builds the 16-byte answer to a reader read of the first mailbox block
`timescale 1ns/1ps
`include "mailbox_cfg.svh"
module mailbox_resp #(
  parameter int BYTES = `BUF_BYTES
) (
  input  wire logic [8*BYTES-1:0] mem_in,       // Buffer bytes
  input  wire logic               host_rdy_in,  // Host message pending
  input  wire logic               host_busy_in, // Host side occupied
  output logic      [8*BYTES-1:0] resp_out      // Answer bytes
);
  logic [7:0] flags;

  // Ready with no busy reads as one; busy rides in bit 1
  // ready reads one
  always_comb begin
    flags = 8'h00;
    flags[`ST_HOST_RDY]  = host_rdy_in;
    flags[`ST_HOST_BUSY] = host_busy_in & ~host_rdy_in;
  end

  // Twelve data bytes only when data is ready, then three empty, then flags
  // fixed answer layout
  assign resp_out = {flags, 24'h000000,
                     host_rdy_in ? mem_in[8*`HOST_BYTES-1:0] : {8*`HOST_BYTES{1'b0}}};
endmodule
